// ---- common/smid_pkg.sv ----
package smid_pkg;
	// register offsets (byte addresses, one word each)
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_FWD_TLIM = 8'h04;
	localparam logic [7:0] ADDR_REV_TLIM = 8'h08;
	localparam logic [7:0] ADDR_TFULL    = 8'h0C;
	localparam logic [7:0] ADDR_TOFFSET  = 8'h10;
	localparam logic [7:0] ADDR_ACCEL    = 8'h14;
	localparam logic [7:0] ADDR_DECEL    = 8'h18;
	localparam logic [7:0] ADDR_ISPD1    = 8'h1C;
	localparam logic [7:0] ADDR_ISPD7    = 8'h34;
	localparam logic [7:0] ADDR_STATUS   = 8'h38;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h3C;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h40;
	localparam logic [7:0] ADDR_ZERO_THR = 8'h44;
	localparam logic [7:0] ADDR_REACH_BW = 8'h48;

	// control register fields
	localparam int CTRL_MODE_LSB = 0;  // lowest digit of the mode setting
	localparam int CTRL_ABS_BIT  = 4;  // absolute position system in use
	localparam int CTRL_SEL3_BIT = 5;  // third speed-selection input enabled

	// mode digits
	localparam logic [3:0] MODE_POS_SPEED = 4'h1;
	localparam logic [3:0] MODE_TORQUE    = 4'h4;

	// analog scaling
	localparam int TORQUE_FS_MV   = 8000; // full-scale torque input, mV
	localparam int OFFSET_MAX_MV  = 999;  // offset range +-999 mV

	// reset values
	localparam logic [15:0] RST_TLIM    = 16'h03E8;
	localparam logic [15:0] RST_TFULL   = 16'h03E8;
	localparam logic [15:0] RST_STEP    = 16'h0001;
	localparam logic [15:0] RST_ZERO    = 16'h0032;
	localparam logic [15:0] RST_REACH   = 16'h0014;
	localparam logic [15:0] RST_ISPD    = 16'h0064;

	// interrupt bits
	localparam int IRQ_MODE_CHG = 0;
	localparam int IRQ_REJECT   = 1;
	localparam int IRQ_LIMITING = 2;
	localparam int IRQ_REACHED  = 3;
	localparam int IRQ_W        = 4;

	// operating control law
	typedef enum logic [1:0] {
		SMID_IDLE,
		SMID_TORQUE,
		SMID_POSITION,
		SMID_SPEED
	} smid_law_t;
endpackage : smid_pkg

// ---- verilog/smid_decoder.sv ----
// What this block does
// RULE1: torque command scaled, 8 V gives full-scale
// RULE2: rotation selects set torque sign or none
// RULE3: signed offset up to 999 mV added
// RULE4: torque clamped to fwd/rev limits only
// RULE5: rotation selects set speed-limit direction
// RULE6: three select bits choose speed-limit source
// RULE7: limiting flag when speed reaches limit
// RULE8: operator sets limit 100 r/min above target
// RULE9: change mode on digit 1, not absolute
// RULE10: change input off position, on speed
// RULE11: mode changes only at zero speed
// RULE12: toggle above zero speed never takes effect
// RULE13: position to speed clears droop pulses
// RULE14: two select bits choose speed command
// RULE15: third select bit widens choice to seven
// RULE16: speed command ramps with accel/decel steps
// RULE17: start inputs give direction or servo lock
// RULE18: reached flag when speed near command
// RULE19: discrete inputs synchronised, on means one
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module smid_decoder (
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	// register port
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wr_data_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [31:0] rd_data_o,
	// discrete contacts, asynchronous
	input  wire logic        fwd_rotation_select_i,
	input  wire logic        rev_rotation_select_i,
	input  wire logic        speed_select_bit0_i,
	input  wire logic        speed_select_bit1_i,
	input  wire logic        speed_select_bit2_i,
	input  wire logic        control_change_input_i,
	input  wire logic        forward_start_input_i,
	input  wire logic        reverse_start_input_i,
	// digitised analog values and feedback, same clock
	input  wire logic [15:0] analog_torque_cmd_i,
	input  wire logic [15:0] analog_speed_limit_in_i,
	input  wire logic [15:0] analog_speed_cmd_i,
	input  wire logic [15:0] motor_speed_i,
	// drive outputs
	output logic      [15:0] torque_cmd_o,
	output logic      [15:0] speed_limit_o,
	output logic             speed_limit_ccw_o,
	output logic      [15:0] speed_cmd_o,
	output logic             servo_lock_o,
	output logic             speed_mode_o,
	output logic             position_mode_o,
	output logic             droop_clear_o,
	output logic             speed_limiting_flag_o,
	output logic             speed_reached_flag_o,
	output logic             zero_speed_flag_o,
	output logic             irq_o
);

	// all state of the block
	typedef struct packed {
		logic [7:0]             sync1;      // first synchroniser stage
		logic [7:0]             sync2;      // second stage, usable
		logic                   lop_prev;   // last change input
		logic [5:0]             ctrl;       // mode, abs, sel3
		logic [15:0]            fwd_tlim;   // forward torque limit
		logic [15:0]            rev_tlim;   // reverse torque limit
		logic [15:0]            tfull;      // torque at full scale
		logic [15:0]            toffset;    // signed offset, mV
		logic [15:0]            accel;      // step per cycle rising
		logic [15:0]            decel;      // step per cycle falling
		logic [6:0][15:0]       ispd;       // internal speeds 1..7
		logic [15:0]            zero_thr;   // zero-speed band
		logic [15:0]            reach_bw;   // reached band
		logic [smid_pkg::IRQ_W-1:0] irq_stat; // sticky events
		logic [smid_pkg::IRQ_W-1:0] irq_mask; // enables
		smid_pkg::smid_law_t    law;        // active control law
		logic [15:0]            torque;     // torque output
		logic [15:0]            slim;       // speed limit magnitude
		logic                   slim_ccw;   // limit direction
		logic [15:0]            scmd;       // ramped speed command
		logic                   lock;       // servo lock
		logic                   droop;      // droop clear pulse
		logic                   limiting;   // limiting flag
		logic                   reached;    // reached flag
		logic                   zero_speed_flag;        // zero-speed flag
		logic                   irq;        // interrupt line
		logic                   spd_mode;   // speed law, registered
		logic                   pos_mode;   // position law, registered
		logic [31:0]            rd_data;    // read answer
	} smid_state_t;

	smid_state_t st;       // registered state
	smid_state_t next_st;  // next state

	// combinational scratch
	logic        rs_fwd;
	logic        rs_rev;
	logic        control_change_input;
	logic        st_fwd;
	logic        st_rev;
	logic [2:0]  sel;
	logic [3:0]  mode;
	logic signed [17:0] tc_sum;
	logic signed [17:0] tc_clip;
	logic signed [35:0] tc_prod;
	logic signed [17:0] tc_scaled;
	logic signed [17:0] tq;
	logic signed [15:0] lim_val;
	logic        lim_internal;
	logic signed [15:0] cmd_val;
	logic signed [16:0] target;
	logic signed [16:0] cur;
	logic signed [16:0] stepped;
	logic [15:0] spd_abs;
	logic [15:0] tgt_abs;
	logic [16:0] diff_abs;
	logic        zsp_now;
	logic [smid_pkg::IRQ_W-1:0] events;
	logic [smid_pkg::IRQ_W-1:0] w1c;
	logic [2:0]  ispd_idx;

	// absolute value of a signed 16-bit speed
	function automatic logic [15:0] smid_abs(input logic [15:0] v);
		logic [15:0] r;
		r = v[15] ? 16'(-$signed(v)) : v;
		return r;
	endfunction : smid_abs

	// next-state logic
	always_comb begin
		next_st = st;
		// two-stage synchroniser, contacts active high
		next_st.sync1 = {reverse_start_input_i, forward_start_input_i,
			control_change_input_i, speed_select_bit2_i,
			speed_select_bit1_i, speed_select_bit0_i,
			rev_rotation_select_i, fwd_rotation_select_i}; // see RULE19
		next_st.sync2 = st.sync1; // see RULE19
		rs_fwd = st.sync2[0];
		rs_rev = st.sync2[1];
		control_change_input    = st.sync2[5];
		st_fwd = st.sync2[6];
		st_rev = st.sync2[7];
		mode   = st.ctrl[smid_pkg::CTRL_MODE_LSB +: 4];
		// third select bit only when enabled
		sel = {st.sync2[4] & st.ctrl[smid_pkg::CTRL_SEL3_BIT],
			st.sync2[3], st.sync2[2]}; // see RULE15
		events = '0;
		w1c    = '0;
		next_st.droop = 1'b0;

		// zero-speed detection
		spd_abs = smid_abs(motor_speed_i);
		zsp_now = (spd_abs <= st.zero_thr);
		next_st.zero_speed_flag = zsp_now;

		// law selection
		if (mode == smid_pkg::MODE_TORQUE) begin
			next_st.law = smid_pkg::SMID_TORQUE;
		end else if (mode == smid_pkg::MODE_POS_SPEED &&
			!st.ctrl[smid_pkg::CTRL_ABS_BIT]) begin // see RULE9
			// enter change mode in the law the input asks for
			if (st.law != smid_pkg::SMID_POSITION &&
				st.law != smid_pkg::SMID_SPEED) begin
				next_st.law = control_change_input ? smid_pkg::SMID_SPEED
					: smid_pkg::SMID_POSITION; // see RULE10
			end else if (control_change_input != st.lop_prev) begin
				// edge of the change input
				if (zsp_now) begin // see RULE11
					next_st.law = control_change_input ? smid_pkg::SMID_SPEED
						: smid_pkg::SMID_POSITION; // see RULE10
					events[smid_pkg::IRQ_MODE_CHG] = 1'b1;
					// droop pulses dropped only when leaving position
					if (control_change_input && st.law == smid_pkg::SMID_POSITION) begin
						next_st.droop = 1'b1; // see RULE13
					end
				end else begin
					// change at speed is discarded for good
					events[smid_pkg::IRQ_REJECT] = 1'b1; // see RULE12
				end
			end
		end else begin
			next_st.law = smid_pkg::SMID_IDLE;
		end
		next_st.lop_prev = control_change_input;
		// mode outputs registered beside the law
		next_st.spd_mode = (next_st.law == smid_pkg::SMID_SPEED);
		next_st.pos_mode = (next_st.law == smid_pkg::SMID_POSITION);

		// torque path: offset, scale, sign, clamp
		tc_sum = 18'(signed'(analog_torque_cmd_i))
			+ 18'(signed'(st.toffset)); // see RULE3
		tc_clip = tc_sum;
		if (tc_sum > 18'(smid_pkg::TORQUE_FS_MV)) begin
			tc_clip = 18'(smid_pkg::TORQUE_FS_MV);
		end else if (tc_sum < -18'(smid_pkg::TORQUE_FS_MV)) begin
			tc_clip = -18'(smid_pkg::TORQUE_FS_MV);
		end
		tc_prod = 36'(tc_clip) * 36'(signed'({2'b00, st.tfull}));
		tc_scaled = 18'(tc_prod / 36'(smid_pkg::TORQUE_FS_MV)); // see RULE1
		if (rs_fwd == rs_rev || tc_clip == '0) begin
			tq = '0; // see RULE2
		end else if (rs_fwd) begin
			tq = tc_scaled; // see RULE2
		end else begin
			tq = -tc_scaled; // see RULE2
		end
		// parameter limits only; analog limit input is not used
		if (tq > 18'(signed'({2'b00, st.fwd_tlim}))) begin
			tq = 18'(signed'({2'b00, st.fwd_tlim})); // see RULE4
		end else if (tq < -18'(signed'({2'b00, st.rev_tlim}))) begin
			tq = -18'(signed'({2'b00, st.rev_tlim})); // see RULE4
		end
		next_st.torque = (st.law == smid_pkg::SMID_TORQUE)
			? tq[15:0] : '0;

		// speed-limit source and direction
		lim_internal = (sel != 3'd0);
		lim_val = lim_internal ? signed'(st.ispd[3'(sel - 3'd1)])
			: signed'(analog_speed_limit_in_i); // see RULE6
		if (st.law == smid_pkg::SMID_TORQUE) begin
			next_st.slim = smid_abs(lim_val);
			if (rs_fwd && !rs_rev) begin
				next_st.slim_ccw = lim_internal
					|| !lim_val[15]; // see RULE5
			end else if (rs_rev && !rs_fwd) begin
				next_st.slim_ccw = !lim_internal
					&& lim_val[15]; // see RULE5
			end
			next_st.limiting = (spd_abs >= next_st.slim); // see RULE7
		end else begin
			next_st.slim = '0;
			next_st.limiting = 1'b0;
		end

		// speed command source, two or three select bits
		ispd_idx = 3'(sel - 3'd1);
		cmd_val = (sel == 3'd0) ? signed'(analog_speed_cmd_i)
			: signed'(st.ispd[ispd_idx]); // see RULE14
		// start inputs: direction or servo lock
		if (st_fwd == st_rev) begin
			target = '0; // see RULE17
			next_st.lock = (st.law == smid_pkg::SMID_SPEED);
		end else if (st_fwd) begin
			target = 17'(cmd_val); // see RULE17
			next_st.lock = 1'b0;
		end else begin
			target = -17'(cmd_val); // see RULE17
			next_st.lock = 1'b0;
		end
		if (st.law != smid_pkg::SMID_SPEED) begin
			target = '0;
		end

		// ramp toward the target, even while turning
		cur = 17'(signed'(st.scmd));
		tgt_abs = smid_abs(target[15:0]);
		stepped = cur;
		if (target > cur) begin
			stepped = cur + 17'(signed'({1'b0, (cur[16] ||
				tgt_abs < smid_abs(st.scmd)) ? st.decel
				: st.accel})); // see RULE16
			if (stepped > target) begin
				stepped = target;
			end
		end else if (target < cur) begin
			stepped = cur - 17'(signed'({1'b0, (!cur[16] ||
				tgt_abs < smid_abs(st.scmd)) ? st.decel
				: st.accel})); // see RULE16
			if (stepped < target) begin
				stepped = target;
			end
		end
		if (st.law != smid_pkg::SMID_SPEED) begin
			stepped = '0;
		end
		next_st.scmd = stepped[15:0];

		// reached: feedback within band of the selected command
		diff_abs = 17'(target) - 17'(signed'(motor_speed_i));
		diff_abs = diff_abs[16] ? 17'(-$signed(diff_abs)) : diff_abs;
		next_st.reached = (st.law == smid_pkg::SMID_SPEED)
			&& !next_st.lock
			&& (diff_abs <= {1'b0, st.reach_bw}); // see RULE18

		// rising flag edges become events
		events[smid_pkg::IRQ_LIMITING] = next_st.limiting && !st.limiting;
		events[smid_pkg::IRQ_REACHED]  = next_st.reached && !st.reached;

		// register writes
		next_st.rd_data = '0;
		if (wr_i) begin
			unique case (addr_i)
				smid_pkg::ADDR_CTRL: begin
					next_st.ctrl = wr_data_i[5:0];
				end
				smid_pkg::ADDR_FWD_TLIM: begin
					next_st.fwd_tlim = wr_data_i[15:0];
				end
				smid_pkg::ADDR_REV_TLIM: begin
					next_st.rev_tlim = wr_data_i[15:0];
				end
				smid_pkg::ADDR_TFULL: begin
					next_st.tfull = wr_data_i[15:0];
				end
				smid_pkg::ADDR_TOFFSET: begin
					// offset saturates at +-999 mV
					if (signed'(wr_data_i[15:0]) >
						16'(smid_pkg::OFFSET_MAX_MV)) begin
						next_st.toffset = 16'(smid_pkg::OFFSET_MAX_MV);
					end else if (signed'(wr_data_i[15:0]) <
						-16'(smid_pkg::OFFSET_MAX_MV)) begin
						next_st.toffset = -16'(smid_pkg::OFFSET_MAX_MV);
					end else begin
						next_st.toffset = wr_data_i[15:0]; // see RULE3
					end
				end
				smid_pkg::ADDR_ACCEL: begin
					next_st.accel = wr_data_i[15:0];
				end
				smid_pkg::ADDR_DECEL: begin
					next_st.decel = wr_data_i[15:0];
				end
				smid_pkg::ADDR_IRQ_STAT: begin
					w1c = wr_data_i[smid_pkg::IRQ_W-1:0];
				end
				smid_pkg::ADDR_IRQ_MASK: begin
					next_st.irq_mask = wr_data_i[smid_pkg::IRQ_W-1:0];
				end
				smid_pkg::ADDR_ZERO_THR: begin
					next_st.zero_thr = wr_data_i[15:0];
				end
				smid_pkg::ADDR_REACH_BW: begin
					next_st.reach_bw = wr_data_i[15:0];
				end
				default: begin
					// internal speeds 1..7, others ignored
					if (addr_i >= smid_pkg::ADDR_ISPD1 &&
						addr_i <= smid_pkg::ADDR_ISPD7 &&
						addr_i[1:0] == 2'b00) begin
						next_st.ispd[3'((addr_i
							- smid_pkg::ADDR_ISPD1) >> 2)]
							= wr_data_i[15:0];
					end
				end
			endcase
		end

		// sticky events, a new event beats the clear
		next_st.irq_stat = (st.irq_stat & ~w1c) | events;
		next_st.irq = |(next_st.irq_stat & next_st.irq_mask);

		// register reads, answer one cycle later
		if (rd_i) begin
			unique case (addr_i)
				smid_pkg::ADDR_CTRL:     next_st.rd_data = 32'(st.ctrl);
				smid_pkg::ADDR_FWD_TLIM: next_st.rd_data = 32'(st.fwd_tlim);
				smid_pkg::ADDR_REV_TLIM: next_st.rd_data = 32'(st.rev_tlim);
				smid_pkg::ADDR_TFULL:    next_st.rd_data = 32'(st.tfull);
				smid_pkg::ADDR_TOFFSET:  next_st.rd_data = 32'(st.toffset);
				smid_pkg::ADDR_ACCEL:    next_st.rd_data = 32'(st.accel);
				smid_pkg::ADDR_DECEL:    next_st.rd_data = 32'(st.decel);
				smid_pkg::ADDR_STATUS: begin
					// live block state
					next_st.rd_data = {21'h00_0000, st.sync2[5],
						st.lock, st.reached, st.limiting, st.zero_speed_flag,
						st.slim_ccw, st.irq, 2'(st.law), 2'b00};
				end
				smid_pkg::ADDR_IRQ_STAT: next_st.rd_data = 32'(st.irq_stat);
				smid_pkg::ADDR_IRQ_MASK: next_st.rd_data = 32'(st.irq_mask);
				smid_pkg::ADDR_ZERO_THR: next_st.rd_data = 32'(st.zero_thr);
				smid_pkg::ADDR_REACH_BW: next_st.rd_data = 32'(st.reach_bw);
				default: begin
					// internal speeds, unmapped reads zero
					if (addr_i >= smid_pkg::ADDR_ISPD1 &&
						addr_i <= smid_pkg::ADDR_ISPD7 &&
						addr_i[1:0] == 2'b00) begin
						next_st.rd_data = 32'(st.ispd[3'((addr_i
							- smid_pkg::ADDR_ISPD1) >> 2)]);
					end
				end
			endcase
		end
	end

	// state register with synchronous reset
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st          <= '0;
			st.fwd_tlim <= smid_pkg::RST_TLIM;
			st.rev_tlim <= smid_pkg::RST_TLIM;
			st.tfull    <= smid_pkg::RST_TFULL;
			st.accel    <= smid_pkg::RST_STEP;
			st.decel    <= smid_pkg::RST_STEP;
			st.ispd     <= {7{smid_pkg::RST_ISPD}};
			st.zero_thr <= smid_pkg::RST_ZERO;
			st.reach_bw <= smid_pkg::RST_REACH;
			st.law      <= smid_pkg::SMID_IDLE;
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from flops
	assign rd_data_o             = st.rd_data;
	assign torque_cmd_o          = st.torque;
	assign speed_limit_o         = st.slim;
	assign speed_limit_ccw_o     = st.slim_ccw;
	assign speed_cmd_o           = st.scmd;
	assign servo_lock_o          = st.lock;
	assign speed_mode_o          = st.spd_mode;
	assign position_mode_o       = st.pos_mode;
	assign droop_clear_o         = st.droop;
	assign speed_limiting_flag_o = st.limiting;
	assign speed_reached_flag_o  = st.reached;
	assign zero_speed_flag_o     = st.zero_speed_flag;
	assign irq_o                 = st.irq;

endmodule : smid_decoder
`default_nettype wire

// ---- dv/smid_decoder_properties.sv ----
`timescale 1ns/100ps
`default_nettype none
// watches mode, pulse and output relations at the decoder's ports
module smid_checker (
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	input  wire logic [31:0] rd_data_o,
	input  wire logic [15:0] torque_cmd_o,
	input  wire logic [15:0] speed_cmd_o,
	input  wire logic        servo_lock_o,
	input  wire logic        speed_mode_o,
	input  wire logic        position_mode_o,
	input  wire logic        droop_clear_o,
	input  wire logic        zero_speed_flag_o,
	input  wire logic        irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	modes_exclusive_a: assert property (
		!(speed_mode_o && position_mode_o))
		else $error("speed and position modes both active");
	droop_single_a: assert property (
		droop_clear_o |=> !droop_clear_o)
		else $error("droop clear longer than one cycle");
	droop_cause_a: assert property (
		droop_clear_o |-> speed_mode_o && $past(position_mode_o))
		else $error("droop clear without position to speed change");
	switch_zero_a: assert property (
		speed_mode_o && $past(position_mode_o) |-> zero_speed_flag_o)
		else $error("mode switched away from zero speed");
	mode_hold_a: assert property (
		(speed_mode_o || position_mode_o) && !zero_speed_flag_o && !wr_i
		&& !$past(wr_i) && !$past(wr_i, 2)
		|=> $stable(speed_mode_o) && $stable(position_mode_o))
		else $error("mode changed while moving");
	torque_idle_a: assert property (
		speed_mode_o && $past(speed_mode_o) |-> torque_cmd_o == 16'h0000)
		else $error("torque output outside torque law");
	position_quiet_a: assert property (
		position_mode_o && $past(position_mode_o)
		|-> !servo_lock_o && speed_cmd_o == 16'h0000)
		else $error("speed outputs active in position law");
	read_idle_a: assert property (
		!$past(rd_i) |-> rd_data_o == 32'h0000_0000)
		else $error("read data outside its cycle");
	reset_quiet_a: assert property (
		$fell(sys_rst_i) |-> !irq_o && !speed_mode_o && !position_mode_o)
		else $error("outputs active after reset release");
endmodule : smid_checker
bind smid_decoder smid_checker smid_checker_i (
	.clk_i(clk_i), .sys_rst_i(sys_rst_i), .wr_i(wr_i), .rd_i(rd_i),
	.rd_data_o(rd_data_o), .torque_cmd_o(torque_cmd_o),
	.speed_cmd_o(speed_cmd_o), .servo_lock_o(servo_lock_o),
	.speed_mode_o(speed_mode_o), .position_mode_o(position_mode_o),
	.droop_clear_o(droop_clear_o), .zero_speed_flag_o(zero_speed_flag_o),
	.irq_o(irq_o)
);
`default_nettype wire

// ---- dv/smid_ctrl_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// external controller: contact set, analog sources and motor speed
module smid_ctrl_model (
	input  wire logic        clk_i,
	output logic      [7:0]  pins_o,
	output logic      [15:0] torque_mv_o,
	output logic      [15:0] vlim_o,
	output logic      [15:0] vcmd_o,
	output logic      [15:0] speed_o
);
	// requested levels: contacts open, analog at zero, motor at rest
	logic [7:0]  next_pins   = 8'h00;
	logic [15:0] next_torque = 16'h0000;
	logic [15:0] next_vlim   = 16'h0000;
	logic [15:0] next_vcmd   = 16'h0000;
	logic [15:0] next_speed  = 16'h0000;
	// lines follow a request at the next edge, like a settled relay
	always @(posedge clk_i) begin
		pins_o      <= next_pins;
		torque_mv_o <= next_torque;
		vlim_o      <= next_vlim;
		vcmd_o      <= next_vcmd;
		speed_o     <= next_speed;
	end
	// closed contact driven as one, moved just after an edge
	task automatic set_pins(input logic [7:0] p);
		@(posedge clk_i);
		next_pins <= p;
	endtask : set_pins
	// analog sources and speed feedback move together
	task automatic set_an(input logic [15:0] t, input logic [15:0] l,
		input logic [15:0] c, input logic [15:0] s);
		@(posedge clk_i);
		next_torque <= t;
		next_vlim <= l;
		next_vcmd <= c;
		next_speed <= s;
	endtask : set_an
endmodule : smid_ctrl_model
`default_nettype wire

// ---- dv/smid_decoder_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module smid_decoder_tb_top;
	logic        clk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdat = 32'h0000_0000;
	logic        wr_s = 1'b0;
	logic        rd_s = 1'b0;
	logic [31:0] rd_data_o;
	logic [7:0]  pins;
	logic [15:0] tq_mv, vlim, vcmd, spd, torque_cmd_o, speed_limit_o;
	logic [15:0] speed_cmd_o;
	logic        ccw, lock, spd_mode, pos_mode, droop, limiting, reached;
	logic        zero_speed_flag, irq_o;
	logic [31:0] v;
	int          fails = 0;
	int          checked = 0;
	int          pulses = 0;
	// torque per rotation select code at 400 mV
	logic [15:0] tq_exp [4] = '{16'h0000, 16'h0190, 16'hFE70, 16'h0000};
	// 200 MHz clock
	initial begin
		forever #2.5 clk_i = ~clk_i;
	end
	smid_ctrl_model smid_ctrl_model_i (.clk_i(clk_i), .pins_o(pins),
		.torque_mv_o(tq_mv), .vlim_o(vlim), .vcmd_o(vcmd), .speed_o(spd));
	smid_decoder smid_decoder_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.addr_i(addr), .wr_data_i(wdat), .wr_i(wr_s), .rd_i(rd_s),
		.rd_data_o(rd_data_o), .fwd_rotation_select_i(pins[0]),
		.rev_rotation_select_i(pins[1]), .speed_select_bit0_i(pins[2]),
		.speed_select_bit1_i(pins[3]), .speed_select_bit2_i(pins[4]),
		.control_change_input_i(pins[5]), .forward_start_input_i(pins[6]),
		.reverse_start_input_i(pins[7]), .analog_torque_cmd_i(tq_mv),
		.analog_speed_limit_in_i(vlim), .analog_speed_cmd_i(vcmd),
		.motor_speed_i(spd), .torque_cmd_o(torque_cmd_o),
		.speed_limit_o(speed_limit_o), .speed_limit_ccw_o(ccw),
		.speed_cmd_o(speed_cmd_o), .servo_lock_o(lock),
		.speed_mode_o(spd_mode), .position_mode_o(pos_mode),
		.droop_clear_o(droop), .speed_limiting_flag_o(limiting),
		.speed_reached_flag_o(reached), .zero_speed_flag_o(zero_speed_flag),
		.irq_o(irq_o));
	// count droop clear pulses
	always @(posedge clk_i) begin
		if (droop === 1'b1) pulses++;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr <= a;
		wdat <= d;
		wr_s <= 1'b1;
		@(posedge clk_i);
		wr_s <= 1'b0;
	endtask : wr
	// data stand in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_i);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk_i);
		rd_s <= 1'b0;
		#1 d = rd_data_o;
	endtask : rd
	task automatic settle(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : settle
	task automatic final_report();
		if (fails == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : final_report
	// hang guard, far beyond the expected run
	initial begin
		repeat (20000) @(posedge clk_i);
		fails++;
		final_report();
	end
	initial begin
		repeat (2) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		// defaults, unmapped word reads zero
		rd(smid_pkg::ADDR_FWD_TLIM, v);
		check(v, {16'h0000, smid_pkg::RST_TLIM});
		rd(smid_pkg::ADDR_ISPD7, v);
		check(v, {16'h0000, smid_pkg::RST_ISPD});
		rd(8'h4C, v);
		check(v, 32'h0000_0000);
		// torque law at unity full scale, third select on
		wr(smid_pkg::ADDR_TFULL, 32'h0000_1F40);
		wr(smid_pkg::ADDR_CTRL, 32'h0000_0024);
		for (int i = 0; i < 4; i++) begin
			smid_ctrl_model_i.set_pins(8'(i));
			smid_ctrl_model_i.set_an(16'h0190, 16'h0050, 16'h0000, 16'h0000);
			settle(8);
			check(torque_cmd_o, tq_exp[i]);
		end
		smid_ctrl_model_i.set_an(16'h0FA0, 16'h0050, 16'h0000, 16'h0000);
		smid_ctrl_model_i.set_pins(8'h01);
		settle(8);
		check(torque_cmd_o, 16'h03E8);
		wr(smid_pkg::ADDR_REV_TLIM, 32'h0000_012C);
		smid_ctrl_model_i.set_pins(8'h02);
		settle(8);
		check(torque_cmd_o, 16'hFED4);
		smid_ctrl_model_i.set_an(16'h0000, 16'h0050, 16'h0000, 16'h0000);
		smid_ctrl_model_i.set_pins(8'h01);
		settle(8);
		check(torque_cmd_o, 16'h0000);
		wr(smid_pkg::ADDR_TOFFSET, 32'h0000_0BB8);
		settle(8);
		check(torque_cmd_o, 16'h03E7);
		wr(smid_pkg::ADDR_TOFFSET, 32'h0000_0000);
		wr(smid_pkg::ADDR_TFULL, 32'h0000_0190);
		smid_ctrl_model_i.set_an(16'h2710, 16'h0050, 16'h0000, 16'h0000);
		settle(8);
		check(torque_cmd_o, 16'h0190);
		// internal speeds set to 256 times their number, 256 to 1792
		for (int i = 1; i < 8; i++) begin
			wr(smid_pkg::ADDR_ISPD1 + 8'(i * 4 - 4), 32'(i * 256));
		end
		for (int i = 0; i < 8; i++) begin
			smid_ctrl_model_i.set_pins(8'(i * 4 + 1));
			settle(8);
			check(speed_limit_o, (i == 0) ? 16'h0050 : 16'(i * 256));
			check(ccw, 1'b1);
		end
		smid_ctrl_model_i.set_pins(8'h06);
		settle(8);
		check(ccw, 1'b0);
		smid_ctrl_model_i.set_an(16'h0000, 16'hFFB0, 16'h0000, 16'h0000);
		smid_ctrl_model_i.set_pins(8'h02);
		settle(8);
		check({ccw, speed_limit_o}, 17'h1_0050);
		// limiting raises, masks and clears the interrupt
		wr(smid_pkg::ADDR_IRQ_MASK, 32'h0000_0004);
		smid_ctrl_model_i.set_pins(8'h05);
		smid_ctrl_model_i.set_an(16'h0000, 16'h0050, 16'h0000, 16'h0100);
		settle(8);
		check({limiting, irq_o}, 2'b11);
		rd(smid_pkg::ADDR_IRQ_STAT, v);
		check(v & 32'h0000_0004, 32'h0000_0004);
		smid_ctrl_model_i.set_an(16'h0000, 16'h0050, 16'h0000, 16'h0080);
		settle(8);
		check(limiting, 1'b0);
		wr(smid_pkg::ADDR_IRQ_STAT, 32'h0000_0004);
		settle(2);
		check(irq_o, 1'b0);
		wr(smid_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
		smid_ctrl_model_i.set_an(16'h0000, 16'h0050, 16'h0000, 16'h0100);
		settle(8);
		check(irq_o, 1'b0);
		// change mode at rest, then a toggle while moving
		smid_ctrl_model_i.set_an(16'h0000, 16'h0050, 16'h0000, 16'h0000);
		smid_ctrl_model_i.set_pins(8'h00);
		wr(smid_pkg::ADDR_IRQ_STAT, 32'h0000_000F);
		wr(smid_pkg::ADDR_CTRL, 32'h0000_0001);
		settle(8);
		check({spd_mode, pos_mode}, 2'b01);
		pulses = 0;
		smid_ctrl_model_i.set_pins(8'h20);
		settle(8);
		check({spd_mode, pos_mode, 30'(pulses)}, 32'h8000_0001);
		// controller breaks the stop-first habit on purpose
		smid_ctrl_model_i.set_an(16'h0000, 16'h0050, 16'h0000, 16'h0200);
		smid_ctrl_model_i.set_pins(8'h00);
		settle(8);
		check(zero_speed_flag, 1'b0);
		smid_ctrl_model_i.set_an(16'h0000, 16'h0050, 16'h0000, 16'h0000);
		settle(8);
		check({spd_mode, pos_mode}, 2'b10);
		rd(smid_pkg::ADDR_IRQ_STAT, v);
		check(v & 32'h0000_0002, 32'h0000_0002);
		smid_ctrl_model_i.set_pins(8'h20);
		settle(8);
		smid_ctrl_model_i.set_pins(8'h00);
		settle(8);
		check({spd_mode, pos_mode, 30'(pulses)}, 32'h4000_0001);
		wr(smid_pkg::ADDR_CTRL, 32'h0000_0011);
		settle(4);
		check({spd_mode, pos_mode}, 2'b00);
		// speed law: selects, ramp, start inputs
		wr(smid_pkg::ADDR_ACCEL, 32'h0000_0010);
		wr(smid_pkg::ADDR_DECEL, 32'h0000_0010);
		smid_ctrl_model_i.set_pins(8'h74);
		settle(4);
		wr(smid_pkg::ADDR_CTRL, 32'h0000_0001);
		settle(8);
		check(speed_cmd_o > 16'h0000 && speed_cmd_o < 16'h0100, 1'b1);
		settle(40);
		check(speed_cmd_o, 16'h0100);
		smid_ctrl_model_i.set_an(16'h0000, 16'h0050, 16'h0000, 16'h0100);
		settle(8);
		check(reached, 1'b1);
		smid_ctrl_model_i.set_pins(8'hB4);
		settle(60);
		check(speed_cmd_o, 16'hFF00);
		smid_ctrl_model_i.set_pins(8'hF4);
		settle(8);
		check(lock, 1'b1);
		wr(smid_pkg::ADDR_CTRL, 32'h0000_0021);
		smid_ctrl_model_i.set_pins(8'h7C);
		settle(200);
		check(speed_cmd_o, 16'h0700);
		smid_ctrl_model_i.set_an(16'h0000, 16'h0050, 16'h0300, 16'h0000);
		smid_ctrl_model_i.set_pins(8'h60);
		settle(100);
		check(speed_cmd_o, 16'h0300);
		final_report();
	end
endmodule : smid_decoder_tb_top
`default_nettype wire
